// File: design/cseq_addr_if.sv
// interface: operand address request and result between core and resolver
`timescale 1ns/1ps
interface cseq_addr_if;
  import cseq_pkg::*;
  logic [7:0] faddr;
  logic access_sel;
  logic ext_en;
  logic [3:0] bank;
  logic [11:0] index_base;
  logic [11:0] addr;
  cseq_amode_t mode;
  modport core (output faddr, access_sel, ext_en, bank, index_base,
                input addr, mode);
  modport resolver (input faddr, access_sel, ext_en, bank, index_base,
                    output addr, mode);
endinterface

// File: design/cseq_addr_resolve.sv
// module: operand address resolution (access bank, banked, indexed)
`timescale 1ns/1ps
module cseq_addr_resolve
  import cseq_pkg::*;
(
  cseq_addr_if.resolver ai
);
  always_comb
  begin
    if (ai.ext_en && !ai.access_sel && ai.faddr <= CSEQ_ILO_LIMIT)
    begin
      // indexed literal offset: base pointer plus literal
      ai.mode = CSEQ_MODE_INDEXED;
      ai.addr = ai.index_base + {4'h0, ai.faddr};
    end
    else if (!ai.access_sel)
    begin
      // access bank ignores the bank select register
      ai.mode = CSEQ_MODE_ACCESS;
      ai.addr = (ai.faddr < CSEQ_ACC_SPLIT) ? {4'h0, ai.faddr}
                                            : {CSEQ_ACC_HI_BANK, ai.faddr};
    end
    else
    begin
      ai.mode = CSEQ_MODE_BANKED;
      ai.addr = {ai.bank, ai.faddr};
    end
  end
endmodule // cseq_addr_resolve

// File: design/cseq_exec.sv
// module: execution of the compare-skip-if-equal byte instruction
// Summary of operation
// - byte and working register are compared by unsigned subtraction.
// - on equality the fetched next instruction runs as a no-operation.
// - one word, one cycle; two cycles when a one-word skip happens.
// - skipping a two-word instruction takes three cycles in total.
// - access bit zero, extended set off: access bank, bank select ignored.
// - access bit one: the bank select register picks the register bank.
// - extended set, access bit zero, address up to 95: indexed offset.
// - decode in Q1, read in Q2, process in Q3, no write in Q4.
// - every extra skip cycle does nothing in all four phases.
`timescale 1ns/1ps
module cseq_exec
  import cseq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [cseq_pkg::CSEQ_FADDR_W-1:0] faddr_i,
  input wire logic access_sel_i,
  input wire logic ext_en_i,
  input wire logic [cseq_pkg::CSEQ_BANK_W-1:0] bank_select_register_i,
  input wire logic [cseq_pkg::CSEQ_ADDR_W-1:0] index_base_i,
  input wire logic [cseq_pkg::CSEQ_DATA_W-1:0] wreg_i,
  input wire logic [cseq_pkg::CSEQ_DATA_W-1:0] mem_rdata_i,
  input wire logic next_two_word_i,
  output logic busy_o,
  output logic [cseq_pkg::CSEQ_ADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic status_wr_o,
  output logic wreg_wr_o,
  output logic fetch_discard_o,
  output logic skip_o,
  output logic done_o,
  output logic [1:0] phase_o,
  output cseq_pkg::cseq_amode_t amode_o
);
  import cseq_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    cseq_state_t st;
    logic [1:0] ph;
    logic [7:0] faddr;
    logic acc;
    logic ext;
    logic [3:0] bank;
    logic [11:0] base;
    logic [11:0] addr;
    cseq_amode_t mode;
    logic [7:0] wv;
    logic eq;
    logic two;
    logic rd;
    logic discard;
    logic done;
  } cseq_exec_t;

  cseq_exec_t s_q;
  cseq_exec_t s_d;

  cseq_addr_if ai ();

  assign ai.faddr = s_q.faddr;
  assign ai.access_sel = s_q.acc;
  assign ai.ext_en = s_q.ext;
  assign ai.bank = s_q.bank;
  assign ai.index_base = s_q.base;

  cseq_addr_resolve u_resolve (
    .ai(ai)
  );

  // ==========================================================
  // compare by subtraction; borrow is ignored, only zero matters
  function automatic logic bytes_equal(input logic [7:0] f,
                                       input logic [7:0] w);
    logic [7:0] diff;
    diff = f - w;
    return diff == 8'h00;
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.done = 1'b0;
    s_d.discard = 1'b0;
    s_d.ph = s_q.ph + 2'h1;
    unique case (s_q.st)
      CSEQ_IDLE:
      begin
        s_d.ph = CSEQ_Q1;
        if (start_i)
        begin
          // operands latched at start; decode happens in Q1
          s_d.st = CSEQ_EXEC;
          s_d.faddr = faddr_i;
          s_d.acc = access_sel_i;
          s_d.ext = ext_en_i;
          s_d.bank = bank_select_register_i;
          s_d.base = index_base_i;
          s_d.wv = wreg_i;
          s_d.two = next_two_word_i;
        end
      end
      CSEQ_EXEC:
      begin
        if (s_q.ph == CSEQ_Q1)
        begin
          s_d.addr = ai.addr; // decode
          s_d.mode = ai.mode;
          s_d.rd = 1'b1; // read during Q2
        end
        if (s_q.ph == CSEQ_Q3)
          s_d.eq = bytes_equal(mem_rdata_i, s_q.wv);
        if (s_q.ph == CSEQ_Q4)
        begin
          // Q4 writes nothing
          if (s_q.eq)
          begin
            s_d.st = CSEQ_SKIP1;
            s_d.discard = 1'b1;
          end
          else
          begin
            s_d.st = CSEQ_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      CSEQ_SKIP1:
      begin
        // no operation in any phase
        if (s_q.ph == CSEQ_Q4)
        begin
          if (s_q.two)
          begin
            s_d.st = CSEQ_SKIP2; // second word also discarded
            s_d.discard = 1'b1;
          end
          else
          begin
            s_d.st = CSEQ_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      CSEQ_SKIP2:
      begin
        if (s_q.ph == CSEQ_Q4)
        begin
          s_d.st = CSEQ_IDLE; // three cycles total
          s_d.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs; write strobes are tied low since nothing is modified
  assign busy_o = (s_q.st != CSEQ_IDLE);
  assign mem_addr_o = s_q.addr;
  assign mem_rd_o = s_q.rd;
  assign mem_wr_o = 1'b0;
  assign status_wr_o = 1'b0;
  assign wreg_wr_o = 1'b0;
  assign fetch_discard_o = s_q.discard;
  assign skip_o = s_q.eq && (s_q.st == CSEQ_SKIP1 || s_q.st == CSEQ_SKIP2);
  assign done_o = s_q.done;
  assign phase_o = s_q.ph;
  assign amode_o = s_q.mode;

  // ==========================================================
  // checks
  property p_cycles_noskip;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q4 && !s_q.eq)
      |=> done_o && !busy_o;
  endproperty
  a_cycles_noskip: assert property (p_cycles_noskip)
    else $error("no-skip instruction did not end after one cycle");

  property p_skip_one;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q4 && s_q.eq && !s_q.two)
      |=> fetch_discard_o ##4 done_o;
  endproperty
  a_skip_one: assert property (p_skip_one)
    else $error("one-word skip did not take exactly one extra cycle");

  property p_skip_two;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q4 && s_q.eq && s_q.two)
      |=> fetch_discard_o ##4 fetch_discard_o ##4 done_o;
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("two-word skip did not take two extra cycles");

  property p_read_q2;
    @(posedge sys_clk_i) disable iff (reset_i)
    mem_rd_o |-> s_q.st == CSEQ_EXEC && phase_o == CSEQ_Q2;
  endproperty
  a_read_q2: assert property (p_read_q2)
    else $error("memory read outside Q2 of the normal cycle");

  property p_skip_quiet;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_SKIP1 || s_q.st == CSEQ_SKIP2)
      |-> !mem_rd_o && !mem_wr_o && !wreg_wr_o && !status_wr_o
          && $stable(mem_addr_o) && $stable(amode_o);
  endproperty
  a_skip_quiet: assert property (p_skip_quiet)
    else $error("activity during a skip cycle");

  property p_equal;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q3)
      |=> s_q.eq == ($past(mem_rdata_i) == s_q.wv) [*1];
  endproperty
  a_equal: assert property (p_equal)
    else $error("compare result differs from byte equality");

  property p_access;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q1 && !s_q.acc && !s_q.ext)
      |=> amode_o == CSEQ_MODE_ACCESS;
  endproperty
  a_access: assert property (p_access)
    else $error("access bank not selected");

  property p_banked;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q1 && s_q.acc)
      |=> mem_addr_o == {$past(s_q.bank), $past(s_q.faddr)};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");

  property p_indexed;
    @(posedge sys_clk_i) disable iff (reset_i)
    (s_q.st == CSEQ_EXEC && s_q.ph == CSEQ_Q1 && !s_q.acc && s_q.ext
     && s_q.faddr <= CSEQ_ILO_LIMIT)
      |=> amode_o == CSEQ_MODE_INDEXED;
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal offset mode not used");

  property p_no_write;
    @(posedge sys_clk_i) disable iff (reset_i)
    busy_o |-> !mem_wr_o && !wreg_wr_o && !status_wr_o;
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("write strobe during execution");
endmodule // cseq_exec

// File: design/cseq_pkg.sv
// package: constants and types for the compare-skip-if-equal execution unit
package cseq_pkg;
  localparam int unsigned CSEQ_DATA_W = 8;
  localparam int unsigned CSEQ_FADDR_W = 8;
  localparam int unsigned CSEQ_BANK_W = 4;
  localparam int unsigned CSEQ_ADDR_W = 12;
  // highest file address that uses indexed literal offset in extended mode
  localparam logic [7:0] CSEQ_ILO_LIMIT = 8'h5f;
  // access bank: addresses below CSEQ_ACC_SPLIT map to bank 0, the rest to the top bank
  localparam logic [7:0] CSEQ_ACC_SPLIT = 8'h60;
  localparam logic [3:0] CSEQ_ACC_HI_BANK = 4'hf;
  // phase counter values
  localparam logic [1:0] CSEQ_Q1 = 2'h0;
  localparam logic [1:0] CSEQ_Q2 = 2'h1;
  localparam logic [1:0] CSEQ_Q3 = 2'h2;
  localparam logic [1:0] CSEQ_Q4 = 2'h3;

  typedef enum logic [1:0] {
    CSEQ_IDLE = 2'b00,
    CSEQ_EXEC = 2'b01,
    CSEQ_SKIP1 = 2'b10,
    CSEQ_SKIP2 = 2'b11
  } cseq_state_t;

  typedef enum logic [1:0] {
    CSEQ_MODE_BANKED = 2'b00,
    CSEQ_MODE_ACCESS = 2'b01,
    CSEQ_MODE_INDEXED = 2'b10
  } cseq_amode_t;
endpackage

// File: tb/cseq_mem_model.sv
// partner: data memory answering the operand read of the execution unit
`timescale 1ns/1ps
module cseq_mem_model
(
  input wire logic sys_clk_i,
  input wire logic [11:0] addr_i,
  input wire logic rd_en_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [4096];
  logic [7:0] data_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic valid_q = 1'b0;
  // data stands only in the cycle after the read strobe; elsewhere the bus
  // toggles, so an early or late sample cannot match
  assign rdata_o = valid_q ? data_q : ~last_q;
  always @(posedge sys_clk_i)
  begin
    valid_q <= rd_en_i;
    if (rd_en_i)
      data_q <= mem[addr_i];
    last_q <= rdata_o;
  end
endmodule // cseq_mem_model

// File: tb/tb.sv
// testbench: directed and random runs of the compare-skip execution unit
`timescale 1ns/1ps
module tb;
  import cseq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  logic [7:0] faddr_i = 8'h00;
  logic access_sel_i = 1'b0;
  logic ext_en_i = 1'b0;
  logic [3:0] bank_i = 4'h0;
  logic [11:0] base_i = 12'h000;
  logic [7:0] wreg_i = 8'h00;
  logic two_i = 1'b0;
  logic [7:0] rdata;
  logic busy, mem_rd, mem_wr, st_wr, w_wr, disc, skip, done;
  logic [11:0] maddr;
  logic [1:0] phase;
  cseq_amode_t amode;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] fs [5] = '{8'h10, 8'h10, 8'h70, 8'h5f, 8'h60};
  bit as_t [5] = '{1, 0, 0, 0, 0};
  bit es_t [5] = '{0, 0, 0, 1, 1};

  always #2 sys_clk_i = ~sys_clk_i;

  cseq_exec u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .start_i(start_i), .faddr_i(faddr_i), .access_sel_i(access_sel_i),
    .ext_en_i(ext_en_i), .bank_select_register_i(bank_i),
    .index_base_i(base_i), .wreg_i(wreg_i), .mem_rdata_i(rdata),
    .next_two_word_i(two_i), .busy_o(busy), .mem_addr_o(maddr),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .status_wr_o(st_wr),
    .wreg_wr_o(w_wr), .fetch_discard_o(disc), .skip_o(skip),
    .done_o(done), .phase_o(phase), .amode_o(amode));

  cseq_mem_model u_mem (.sys_clk_i(sys_clk_i), .addr_i(maddr),
    .rd_en_i(mem_rd), .rdata_o(rdata));

  // ==========================================================
  // checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // one instruction against the reference model
  task automatic run_op(input logic [7:0] f, input bit a, e,
    input logic [3:0] b, input logic [11:0] x, input logic [7:0] w,
    input bit eq, two, poke);
    int ea, em, n, rds, dis, sk;
    n = 0;
    rds = 0;
    dis = 0;
    sk = 0;
    if (a)
    begin
      ea = {b, f};
      em = 0;
    end
    else if (e && f <= 8'h5f)
    begin
      ea = (x + f) % 4096;
      em = 2;
    end
    else
    begin
      ea = (f < 8'h60) ? f : 'hf00 + f;
      em = 1;
    end
    u_mem.mem[ea] = eq ? w : w ^ 8'($urandom_range(1, 255));
    faddr_i = f;
    access_sel_i = a;
    ext_en_i = e;
    bank_i = b;
    base_i = x;
    wreg_i = w;
    two_i = two;
    start_i = 1'b1;
    while (n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
      chk(mem_wr | st_wr | w_wr, 0);
      if (n == 1)
        chk({busy, phase}, {1'b1, CSEQ_Q1});
      if (mem_rd === 1'b1)
      begin
        rds++;
        chk(n, 2);
        chk(maddr, ea);
        chk(amode, em);
      end
      dis += int'(disc === 1'b1);
      sk += int'(skip === 1'b1);
      if (done === 1'b1)
        break;
      // a second start while busy must be ignored
      start_i = poke && n == 1;
    end
    chk(n, eq ? (two ? 13 : 9) : 5);
    chk(rds, 1);
    chk(dis, eq ? (two ? 2 : 1) : 0);
    chk(sk, eq ? (two ? 8 : 4) : 0);
    chk(busy, 0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(96581));
    repeat (20) @(negedge sys_clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 15; i++)
      run_op(fs[i / 3], as_t[i / 3], es_t[i / 3], 4'h9, 12'hfe0,
        8'($urandom), i % 3 != 0, i % 3 == 2, i == 4);
    for (int i = 0; i < 40; i++)
      run_op(8'($urandom), 1'($urandom), 1'($urandom), 4'($urandom),
        12'($urandom), 8'($urandom), 1'($urandom), 1'($urandom), 0);
    // reset in mid-instruction leaves the unit idle
    start_i = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b1;
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    chk({busy, done, disc}, 0);
    run_op(8'h20, 1, 0, 4'h3, 12'h000, 8'h5a, 1, 1, 0);
    end_sim();
  end

  // hang guard: far beyond the few hundred cycles the runs need
  initial
  begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule // tb
